// *** rtl/mtma_pkg.sv ***
package mtma_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam longint CLK_HZ = 10_000_000;
   localparam longint SECONDS_PER_HOUR = 3600;
   localparam longint TEST_TIMEOUT_HOURS = 9;
   localparam longint TEST_TIMEOUT_CYCLES = TEST_TIMEOUT_HOURS * SECONDS_PER_HOUR * CLK_HZ;
   localparam longint KEY_HOLD_SECONDS = 5;
   localparam longint KEY_HOLD_CYCLES = KEY_HOLD_SECONDS * CLK_HZ;

   ////////////////////////////////////////////////////////////////////////////
   // Widths and limits
   localparam int ACC_W = 48;
   localparam int TEMP_W = 16;
   localparam int VOL_W = 24;
   localparam int COEF_W = 16;
   localparam int TIMER_W = 48;
   localparam logic [4:0] MAX_RECONFIG = 5'd25;
   localparam logic [4:0] RECONFIG_RESET = 5'h00;
   localparam logic [ACC_W-1:0] ACC_RESET = '0;

   ////////////////////////////////////////////////////////////////////////////
   // Scaling: energy Wh = vol[10 ml] * dT[0.01 K] * k[1e-4 Wh/(l K)] / divisor
   localparam longint ENERGY_DIVISOR = 64'd100_000_000;
   // Product scaling: litres per volume count and litre*0.01C per product LSB
   localparam logic [16:0] VOL_L_DEC0 = 17'h003E8;
   localparam logic [16:0] VOL_L_DEC1 = 17'h00064;
   localparam logic [16:0] VOL_L_DEC2 = 17'h0000A;
   localparam logic [16:0] VOL_L_DEC3 = 17'h00001;
   localparam logic [39:0] PROD_LSB_DEC0 = 40'd10000000;
   localparam logic [39:0] PROD_LSB_DEC1 = 40'd1000000;
   localparam logic [39:0] PROD_LSB_DEC2 = 40'd100000;
   localparam logic [39:0] PROD_LSB_DEC3 = 40'd10000;
   // High-resolution volume steps in 10 ml per volume count
   localparam logic [ACC_W-1:0] HIRES_STEP_DEC0 = 48'd100000;
   localparam logic [ACC_W-1:0] HIRES_STEP_DEC1 = 48'd10000;
   localparam logic [ACC_W-1:0] HIRES_STEP_DEC2 = 48'd1000;
   localparam logic [ACC_W-1:0] HIRES_STEP_DEC3 = 48'd100;

   // Formula index of the integrated energies
   localparam int IDX_HEAT = 0;
   localparam int IDX_COOL = 1;
   localparam int IDX_DISC = 2;
   localparam int IDX_ADD = 3;
   localparam int N_INTEG = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {MTMA_DEC0, MTMA_DEC1, MTMA_DEC2, MTMA_DEC3} mtma_decimals_type;

   typedef enum {MTMA_USER, MTMA_TEST} mtma_mode_type;

   typedef struct packed {
      logic signed [TEMP_W-1:0] inlet_temperature;
      logic signed [TEMP_W-1:0] outlet_temperature;
      logic signed [TEMP_W-1:0] outlet_reference;
   } mtma_temps_type;

   typedef struct packed {
      logic inlet_fault;
      logic outlet_fault;
      logic flow_fault;
   } mtma_faults_type;

   typedef struct packed {
      logic [ACC_W-1:0] heat_energy_total;
      logic [ACC_W-1:0] cooling_energy_total;
      logic [ACC_W-1:0] discount_heat_energy;
      logic [ACC_W-1:0] addition_heat_energy;
      logic [ACC_W-1:0] inlet_volume_temp_product;
      logic [ACC_W-1:0] outlet_volume_temp_product;
      logic [ACC_W-1:0] hires_volume;
   } mtma_accum_type;

   typedef struct packed {
      logic inlet_reading;
      logic outlet_reading;
      logic delta_reading;
      logic flow_reading;
      logic power_reading;
   } mtma_dashes_type;

endpackage

// *** rtl/mtma_pin_sync.sv ***
`timescale 1ns/1ns
module mtma_pin_sync
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic level
);
   logic stage1_reg;
   logic stage2_reg;
   logic stage3_reg;

   // First stage feeds only the second
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
         stage3_reg <= 1'b0;
      end
      else
      begin
         stage1_reg <= pin;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   // A change counts once stages two and three agree
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         level <= 1'b0;
      else if (stage2_reg == stage3_reg)
         level <= stage3_reg;
   end
endmodule

// *** rtl/mtma_core.sv ***
`timescale 1ns/1ns
module mtma_core
#(
   parameter longint TEST_TIMEOUT = mtma_pkg::TEST_TIMEOUT_CYCLES,
   parameter longint KEY_HOLD = mtma_pkg::KEY_HOLD_CYCLES
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic test_contacts_shorted,
   input wire logic primary_key,
   input wire logic total_reset,
   input wire logic reconfig_request,
   input wire logic integration_strobe,
   input wire logic volume_count,
   input wire logic [mtma_pkg::VOL_W-1:0] integration_volume,
   input wire logic [mtma_pkg::COEF_W-1:0] heat_coefficient,
   input wire mtma_pkg::mtma_decimals_type volume_decimals,
   input wire mtma_pkg::mtma_temps_type temps,
   input wire mtma_pkg::mtma_faults_type faults,
   output logic test_mode,
   output logic show_first_user_reading,
   output logic reconfig_accepted,
   output logic reconfig_refused,
   output logic [4:0] reconfig_count,
   output mtma_pkg::mtma_accum_type accum,
   output mtma_pkg::mtma_dashes_type dashes
);
   import mtma_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic contacts_level;
   logic key_level;

   mtma_pin_sync contact_sync
   (
      .clk(clk),
      .rst_n(rst_n),
      .pin(test_contacts_shorted),
      .level(contacts_level)
   );

   mtma_pin_sync key_sync
   (
      .clk(clk),
      .rst_n(rst_n),
      .pin(primary_key),
      .level(key_level)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Test mode
   localparam logic [TIMER_W-1:0] TIMEOUT_LAST = TIMER_W'(TEST_TIMEOUT - 1);
   localparam logic [TIMER_W-1:0] KEY_LAST = TIMER_W'(KEY_HOLD - 1);

   mtma_mode_type mode_reg;
   logic contacts_prev_reg;
   logic [TIMER_W-1:0] timeout_reg;
   logic [TIMER_W-1:0] key_hold_reg;
   logic timeout_hit;
   logic key_hit;
   logic contacts_rise;

   assign contacts_rise = contacts_level && !contacts_prev_reg;
   assign timeout_hit = (mode_reg == MTMA_TEST) && (timeout_reg == TIMEOUT_LAST);
   assign key_hit = (mode_reg == MTMA_TEST) && key_level && (key_hold_reg == KEY_LAST);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         contacts_prev_reg <= 1'b0;
      else
         contacts_prev_reg <= contacts_level;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         mode_reg <= MTMA_USER;
      else
      begin
         case (mode_reg)
            MTMA_USER:
               if (contacts_rise)
                  mode_reg <= MTMA_TEST;
            MTMA_TEST:
               if (timeout_hit || key_hit)
                  mode_reg <= MTMA_USER;
            default:
               mode_reg <= MTMA_USER;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n || mode_reg != MTMA_TEST)
         timeout_reg <= '0;
      else
         timeout_reg <= timeout_reg + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n || mode_reg != MTMA_TEST || !key_level)
         key_hold_reg <= '0;
      else
         key_hold_reg <= key_hold_reg + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         show_first_user_reading <= 1'b0;
      else
         show_first_user_reading <= timeout_hit || key_hit;
   end

   assign test_mode = (mode_reg == MTMA_TEST);

   ////////////////////////////////////////////////////////////////////////////
   // Reconfiguration log
   // log and limit
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         reconfig_count <= RECONFIG_RESET;
         reconfig_accepted <= 1'b0;
         reconfig_refused <= 1'b0;
      end
      else
      begin
         reconfig_accepted <= reconfig_request && (reconfig_count < MAX_RECONFIG);
         reconfig_refused <= reconfig_request && (reconfig_count >= MAX_RECONFIG);
         if (reconfig_request && reconfig_count < MAX_RECONFIG)
            reconfig_count <= reconfig_count + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Integrated energies
   logic signed [TEMP_W:0] t_in;
   logic signed [TEMP_W:0] t_out;
   logic signed [TEMP_W:0] t_ref;
   logic [TEMP_W:0] delta [N_INTEG];
   logic allow [N_INTEG];
   logic any_fault;
   logic clear_all;

   assign t_in = (TEMP_W + 1)'(temps.inlet_temperature);
   assign t_out = (TEMP_W + 1)'(temps.outlet_temperature);
   assign t_ref = (TEMP_W + 1)'(temps.outlet_reference);
   assign any_fault = faults.inlet_fault || faults.outlet_fault || faults.flow_fault;
   assign clear_all = !rst_n || total_reset;

   always_comb
   begin
      delta[IDX_HEAT] = (TEMP_W + 1)'(t_in - t_out);
      delta[IDX_COOL] = (TEMP_W + 1)'(t_out - t_in);
      delta[IDX_DISC] = (TEMP_W + 1)'(t_ref - t_out);
      delta[IDX_ADD] = (TEMP_W + 1)'(t_out - t_ref);
      allow[IDX_HEAT] = t_in > t_out;
      allow[IDX_COOL] = t_in < t_out;
      allow[IDX_DISC] = t_ref > t_out;
      allow[IDX_ADD] = t_out > t_ref;
   end

   logic [ACC_W-1:0] energy_reg [N_INTEG];

   genvar g;
   generate
      for (g = 0; g < N_INTEG; g++)
      begin : integ
         logic [63:0] residue_reg;
         logic [63:0] sum;
         assign sum = residue_reg + 64'(integration_volume) * 64'(delta[g])
                      * 64'(heat_coefficient);
         always_ff @(posedge clk)
         begin
            if (clear_all)
            begin
               energy_reg[g] <= ACC_RESET;
               residue_reg <= '0;
            end
            // stop on fault, 1 Wh steps
            else if (integration_strobe && allow[g] && !any_fault)
            begin
               energy_reg[g] <= energy_reg[g] + ACC_W'(sum / ENERGY_DIVISOR);
               residue_reg <= sum % ENERGY_DIVISOR;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Volume and volume-temperature products
   logic [16:0] litres_per_count;
   logic [39:0] prod_lsb;
   logic [ACC_W-1:0] hires_step;

   always_comb
   begin
      case (volume_decimals)
         MTMA_DEC0:
         begin
            litres_per_count = VOL_L_DEC0;
            prod_lsb = PROD_LSB_DEC0;
            hires_step = HIRES_STEP_DEC0;
         end
         MTMA_DEC1:
         begin
            litres_per_count = VOL_L_DEC1;
            prod_lsb = PROD_LSB_DEC1;
            hires_step = HIRES_STEP_DEC1;
         end
         MTMA_DEC3:
         begin
            litres_per_count = VOL_L_DEC3;
            prod_lsb = PROD_LSB_DEC3;
            hires_step = HIRES_STEP_DEC3;
         end
         default:
         begin
            litres_per_count = VOL_L_DEC2;
            prod_lsb = PROD_LSB_DEC2;
            hires_step = HIRES_STEP_DEC2;
         end
      endcase
   end

   logic [ACC_W-1:0] hires_volume_reg;

   // 10 ml steps, stop on flow fault
   always_ff @(posedge clk)
   begin
      if (clear_all)
         hires_volume_reg <= ACC_RESET;
      else if (volume_count && !faults.flow_fault)
         hires_volume_reg <= hires_volume_reg + hires_step;
   end

   logic [TEMP_W-1:0] prod_temp [2];
   logic prod_allow [2];
   logic [ACC_W-1:0] product_reg [2];

   always_comb
   begin
      prod_temp[0] = temps.inlet_temperature[TEMP_W-1] ? '0 : temps.inlet_temperature;
      prod_temp[1] = temps.outlet_temperature[TEMP_W-1] ? '0 : temps.outlet_temperature;
      prod_allow[0] = !faults.inlet_fault && !faults.flow_fault;
      prod_allow[1] = !faults.outlet_fault && !faults.flow_fault;
   end

   generate
      for (g = 0; g < 2; g++)
      begin : prod
         logic [39:0] residue_reg;
         logic [39:0] sum;
         logic [39:0] rem;
         logic [1:0] carry;
         assign sum = residue_reg + 40'(litres_per_count) * 40'(prod_temp[g]);
         // At most three LSBs per count up to 300 C
         always_comb
         begin
            if (sum >= 40'(prod_lsb * 3))
            begin
               carry = 2'd3;
               rem = 40'(sum - prod_lsb * 3);
            end
            else if (sum >= 40'(prod_lsb * 2))
            begin
               carry = 2'd2;
               rem = 40'(sum - prod_lsb * 2);
            end
            else if (sum >= prod_lsb)
            begin
               carry = 2'd1;
               rem = sum - prod_lsb;
            end
            else
            begin
               carry = 2'd0;
               rem = sum;
            end
         end
         always_ff @(posedge clk)
         begin
            if (clear_all)
            begin
               product_reg[g] <= ACC_RESET;
               residue_reg <= '0;
            end
            else if (volume_count && prod_allow[g])
            begin
               product_reg[g] <= product_reg[g] + ACC_W'(carry);
               residue_reg <= rem;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   // one coherent snapshot per cycle
   always_comb
   begin
      accum.heat_energy_total = energy_reg[IDX_HEAT];
      accum.cooling_energy_total = energy_reg[IDX_COOL];
      accum.discount_heat_energy = energy_reg[IDX_DISC];
      accum.addition_heat_energy = energy_reg[IDX_ADD];
      accum.inlet_volume_temp_product = product_reg[0];
      accum.outlet_volume_temp_product = product_reg[1];
      accum.hires_volume = hires_volume_reg;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         dashes <= '0;
      else
      begin
         dashes.inlet_reading <= faults.inlet_fault;
         dashes.outlet_reading <= faults.outlet_fault;
         dashes.delta_reading <= faults.inlet_fault || faults.outlet_fault;
         dashes.flow_reading <= faults.flow_fault;
         dashes.power_reading <= any_fault;
      end
   end
endmodule

// *** bench/mtma_technician.sv ***
`timescale 1ns/1ns
module mtma_technician
(
   input wire logic clk,
   input wire logic short_cmd,
   input wire logic hold_cmd,
   output logic test_contacts_shorted,
   output logic primary_key
);
   initial
   begin
      test_contacts_shorted = 1'b0;
      primary_key = 1'b0;
   end

   // Hands move just after the edge, never on it
   always @(posedge clk)
   begin
      test_contacts_shorted <= #1 short_cmd;
      primary_key <= #1 hold_cmd;
   end
endmodule

// *** bench/mtma_core_properties.sv ***
`timescale 1ns/1ns
module mtma_core_properties
#(
   parameter longint TEST_TIMEOUT = 200,
   parameter longint KEY_HOLD = 20
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic test_contacts_shorted,
   input wire logic primary_key,
   input wire logic total_reset,
   input wire logic reconfig_request,
   input wire logic volume_count,
   input wire mtma_pkg::mtma_faults_type faults,
   input wire logic test_mode,
   input wire logic show_first_user_reading,
   input wire logic reconfig_accepted,
   input wire logic reconfig_refused,
   input wire logic [4:0] reconfig_count,
   input wire mtma_pkg::mtma_accum_type accum
);
   import mtma_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////////
   // Time spent in test mode; key margin covers the pin synchroniser
   logic [47:0] mode_cnt_reg;
   logic [47:0] key_cnt_reg;
   always_ff @(posedge clk)
   begin
      if (!rst_n || !test_mode)
      begin
         mode_cnt_reg <= 48'h0;
         key_cnt_reg <= 48'h0;
      end
      else
      begin
         mode_cnt_reg <= mode_cnt_reg + 48'h1;
         key_cnt_reg <= primary_key ? key_cnt_reg + 48'h1 : 48'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   entry_needs_short_a: assert property (
      $rose(test_mode) |-> $past(test_contacts_shorted, 3))
      else $error("test mode entered without contacts");
   timeout_bound_a: assert property (mode_cnt_reg <= TEST_TIMEOUT)
      else $error("test mode outlived its timeout");
   exit_shows_first_a: assert property (
      $fell(test_mode) |-> show_first_user_reading)
      else $error("no first reading on test exit");
   key_exit_bound_a: assert property (key_cnt_reg <= KEY_HOLD + 5)
      else $error("key hold did not end test mode");
   reconfig_accept_a: assert property (
      reconfig_request && reconfig_count < MAX_RECONFIG |=>
      reconfig_accepted && reconfig_count == $past(reconfig_count) + 5'h01)
      else $error("reconfiguration not accepted");
   reconfig_refuse_a: assert property (
      reconfig_request && reconfig_count == MAX_RECONFIG |=>
      reconfig_refused && !reconfig_accepted && $stable(reconfig_count))
      else $error("reconfiguration beyond limit");
   hires_clear_only_a: assert property (
      !total_reset && !volume_count |=> $stable(accum.hires_volume))
      else $error("volume register moved without count");
   product_step_a: assert property (
      !total_reset && !volume_count |=> $stable(accum.inlet_volume_temp_product)
      && $stable(accum.outlet_volume_temp_product))
      else $error("product moved without count");
   total_clear_a: assert property (total_reset |=> accum == '0)
      else $error("total reset left a register");
   flow_fault_stop_a: assert property (
      faults.flow_fault && !total_reset |=> $stable(accum.hires_volume)
      && $stable(accum.inlet_volume_temp_product))
      else $error("counting during flow fault");
endmodule

// *** bench/mtma_core_bench.sv ***
`timescale 1ns/1ns
`define CHK(got, exp) \
   begin \
      check_count++; \
      if ((got) !== (exp)) \
      begin \
         miscompares++; \
         $display("ERROR %0t got %0h exp %0h", $time, got, exp); \
      end \
   end

module mtma_core_bench;
   import mtma_pkg::*;
   localparam longint TMO = 200;
   logic clk;
   logic rst_n;
   logic short_cmd;
   logic hold_cmd;
   logic contacts;
   logic key;
   logic total_reset;
   logic reconfig_request;
   logic integration_strobe;
   logic volume_count;
   logic [VOL_W-1:0] integration_volume;
   logic [COEF_W-1:0] heat_coefficient;
   mtma_decimals_type volume_decimals;
   mtma_temps_type temps;
   mtma_faults_type faults;
   logic test_mode;
   logic show_first;
   logic accepted;
   logic refused;
   logic [4:0] reconfig_count;
   mtma_accum_type accum;
   mtma_dashes_type dashes;
   int check_count = 0;
   int miscompares = 0;

   mtma_technician mtma_technician_i (.clk(clk), .short_cmd(short_cmd),
      .hold_cmd(hold_cmd), .test_contacts_shorted(contacts), .primary_key(key));
   // Short counts keep the run brief
   mtma_core #(.TEST_TIMEOUT(TMO), .KEY_HOLD(20)) mtma_core_i (.clk(clk), .rst_n(rst_n),
      .test_contacts_shorted(contacts), .primary_key(key), .total_reset(total_reset),
      .reconfig_request(reconfig_request), .integration_strobe(integration_strobe),
      .volume_count(volume_count), .integration_volume(integration_volume),
      .heat_coefficient(heat_coefficient), .volume_decimals(volume_decimals),
      .temps(temps), .faults(faults), .test_mode(test_mode),
      .show_first_user_reading(show_first), .reconfig_accepted(accepted),
      .reconfig_refused(refused), .reconfig_count(reconfig_count), .accum(accum),
      .dashes(dashes));

   ////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wait_mode(input logic v, output int n);
      n = 0;
      while (test_mode !== v && n < 1000)
      begin
         tick(1);
         n++;
      end
   endtask

   task automatic integ;
      integration_strobe = 1'b1;
      tick(1);
      integration_strobe = 1'b0;
      tick(1);
   endtask

   task automatic pulses(input int n);
      volume_count = 1'b1;
      tick(n);
      volume_count = 1'b0;
      tick(1);
   endtask

   task automatic close_out;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_key;
      int n;
      short_cmd = 1'b1;
      wait_mode(1'b1, n);
      `CHK(test_mode, 1'b1)
      short_cmd = 1'b0;
      tick(100);
      hold_cmd = 1'b1;
      tick(10);
      hold_cmd = 1'b0;
      tick(10);
      `CHK(test_mode, 1'b1)
      hold_cmd = 1'b1;
      wait_mode(1'b0, n);
      `CHK(show_first, 1'b1)
      `CHK(n >= 20 && n <= 30, 1'b1)
      hold_cmd = 1'b0;
      tick(10);
   endtask

   // Full timeout after an earlier key exit shows the count restarts
   task automatic t_timeout;
      int n;
      short_cmd = 1'b1;
      wait_mode(1'b1, n);
      wait_mode(1'b0, n);
      `CHK(n >= TMO - 1 && n <= TMO + 1, 1'b1)
      `CHK(show_first, 1'b1)
      tick(10);
      `CHK(test_mode, 1'b0)
      short_cmd = 1'b0;
      tick(10);
   endtask

   task automatic t_integ;
      integration_volume = 24'h0186A0;
      heat_coefficient = 16'h2D50;
      temps = {16'h1B58, 16'h0BB8, 16'h1388};
      integ();
      `CHK(accum[335:144], {48'hB540, 48'h0, 48'h5AA0, 48'h0})
      temps = {16'h0BB8, 16'h1B58, 16'h1388};
      integ();
      `CHK(accum[335:144], {48'hB540, 48'hB540, 48'h5AA0, 48'h5AA0})
      faults = 3'b100;
      integ();
      `CHK(accum[335:144], {48'hB540, 48'hB540, 48'h5AA0, 48'h5AA0})
      `CHK(dashes, 5'h15)
      faults = 3'b000;
   endtask

   task automatic t_reconfig;
      logic [7:0] acc;
      logic [7:0] rej;
      acc = 8'h00;
      rej = 8'h00;
      reconfig_request = 1'b1;
      for (int i = 0; i < 27; i++)
      begin
         tick(1);
         if (i == 25)
            reconfig_request = 1'b0;
         acc = acc + accepted;
         rej = rej + refused;
      end
      `CHK(acc, 8'h19)
      `CHK(rej, 8'h01)
      `CHK(reconfig_count, 5'h19)
      `CHK(accum[335:144], {48'hB540, 48'hB540, 48'h5AA0, 48'h5AA0})
   endtask

   // Every scale gives 0.95 product per count at 95 C
   task automatic t_volume;
      logic [47:0] hv;
      logic [47:0] pi;
      logic [47:0] po;
      hv = 48'h0;
      pi = 48'h0;
      po = 48'h0;
      total_reset = 1'b1;
      tick(1);
      total_reset = 1'b0;
      `CHK(accum, 336'h0)
      temps = {16'h251C, 16'h1194, 16'h1388};
      for (int d = 0; d < 4; d++)
      begin
         volume_decimals = mtma_decimals_type'(d[1:0]);
         pulses(100);
         hv = hv + 48'h64 * (48'h186A0 / (48'hA ** d));
         pi = pi + 48'h5F;
         po = po + 48'h2D;
         `CHK(accum.hires_volume, hv)
         `CHK(accum.inlet_volume_temp_product, pi)
         `CHK(accum.outlet_volume_temp_product, po)
      end
      volume_decimals = MTMA_DEC2;
      faults = 3'b001;
      pulses(10);
      `CHK(accum[143:0], {pi, po, hv})
      `CHK(dashes, 5'h03)
      faults = 3'b100;
      pulses(100);
      `CHK(accum[143:0], {pi, po + 48'h2D, hv + 48'h186A0})
      faults = 3'b010;
      pulses(100);
      `CHK(accum[143:0], {pi + 48'h5F, po + 48'h2D, hv + 48'h30D40})
      `CHK(dashes, 5'h0D)
      faults = 3'b000;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial
   begin
      repeat (6000) @(posedge clk);
      miscompares++;
      close_out();
   end

   initial
   begin
      rst_n = 1'b0;
      short_cmd = 1'b0;
      hold_cmd = 1'b0;
      total_reset = 1'b0;
      reconfig_request = 1'b0;
      integration_strobe = 1'b0;
      volume_count = 1'b0;
      integration_volume = 24'h000000;
      heat_coefficient = 16'h0000;
      volume_decimals = MTMA_DEC2;
      temps = 48'h0;
      faults = 3'b000;
      repeat (16) @(posedge clk);
      #1;
      rst_n = 1'b1;
      tick(1);
      `CHK(accum, 336'h0)
      t_key();
      t_timeout();
      t_integ();
      t_reconfig();
      t_volume();
      close_out();
   end
endmodule

bind mtma_core mtma_core_properties #(.TEST_TIMEOUT(TEST_TIMEOUT), .KEY_HOLD(KEY_HOLD))
   mtma_core_properties_i (.clk(clk), .rst_n(rst_n),
   .test_contacts_shorted(test_contacts_shorted), .primary_key(primary_key),
   .total_reset(total_reset), .reconfig_request(reconfig_request),
   .volume_count(volume_count), .faults(faults), .test_mode(test_mode),
   .show_first_user_reading(show_first_user_reading),
   .reconfig_accepted(reconfig_accepted), .reconfig_refused(reconfig_refused),
   .reconfig_count(reconfig_count), .accum(accum));
